// ==== trp_pkg.sv ====
// Constants and carriers for the timer reload and compare/capture registers.
// Assumes a 32-bit APB master and an external counter, prescaler and control block.
package trp_pkg;

  localparam int unsigned NUM_TIMERS = 3;

  // Register indices; byte address is four times the index
  localparam logic [29:0] IDX_RELOAD_HIGH  = 30'h00ffe302;
  localparam logic [29:0] IDX_RELOAD_LOW   = 30'h00ffe303;
  localparam logic [29:0] IDX_COMPARE_HIGH = 30'h00ffe304;
  localparam logic [29:0] IDX_COMPARE_LOW  = 30'h00ffe305;
  localparam logic [29:0] IDX_STRIDE       = 30'h00000010;

  localparam logic [7:0]  RST_RELOAD_HIGH  = 8'hff;
  localparam logic [7:0]  RST_RELOAD_LOW   = 8'hff;
  localparam logic [7:0]  RST_COMPARE_HIGH = 8'h00;
  localparam logic [7:0]  RST_COMPARE_LOW  = 8'h00;
  localparam logic [7:0]  RST_HOLD_HIGH    = 8'hff;

  // Value the counter restarts from after reaching the reload value
  localparam logic [15:0] RELOAD_START     = 16'h0001;

  typedef enum logic [1:0] {
    TRP_REG_RELOAD_HIGH,
    TRP_REG_RELOAD_LOW,
    TRP_REG_COMPARE_HIGH,
    TRP_REG_COMPARE_LOW
  } trp_reg_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] inst;
    trp_reg_t   sel;
  } trp_dec_t;

  // Per-timer inputs from the counter and control block
  typedef struct packed {
    logic [15:0] count;
    logic        count_tick;
    logic        capture_mode;
    logic        capture_event;
    logic        output_polarity_bit;
  } trp_timer_in_t;

  typedef struct packed {
    logic [15:0] reload_value;
    logic        reload_hit;
    logic        compare_match;
    logic        pwm_out;
  } trp_timer_out_t;

  typedef struct packed {
    logic [7:0] hold_high;
    logic [7:0] reload_high_field;
    logic [7:0] reload_low_field;
    logic [7:0] compare_high_field;
    logic [7:0] compare_low_field;
    logic       pwm_state;
    logic       pwm_out;
  } trp_timer_state_t;

  typedef struct packed {
    trp_timer_state_t [NUM_TIMERS-1:0] tmr;
  } trp_state_t;

endpackage : trp_pkg

// ==== trp_timer_reload_pwm_regs.sv ====
// Reload and compare/capture registers for three 16-bit timers, APB slave.
// Holds the committed reload value, the reload holding byte, the compare
// value and the toggling output of each timer.
// Assumes the counter, prescaler and control registers live outside and
// feed count, tick, capture and polarity per timer; zero-wait APB.
// The outside counter loads RELOAD_START whenever reload_hit is high.
module trp_timer_reload_pwm_regs (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  trp_pkg::trp_timer_in_t  [2:0] tmr_in,
  output trp_pkg::trp_timer_out_t [2:0] tmr_out
);

  // Registered state of all three timers
  trp_pkg::trp_state_t state_q;
  trp_pkg::trp_state_t state_d;

  // Decoded view of the current APB phase
  trp_pkg::trp_dec_t   dec;
  logic                access;
  logic                wr_en;
  logic                rd_en;
  logic [7:0]          rd_byte;

  // Per-timer strobes, bit i belongs to timer i
  logic [2:0]          wr_hold_high;
  logic [2:0]          wr_commit_low;
  logic [2:0]          wr_cmp_high;
  logic [2:0]          wr_cmp_low;
  logic [2:0]          capture_load;
  logic [2:0]          toggle;

  // Register index of one register of one timer
  function automatic logic [29:0] trp_index(input int unsigned        inst,
                                            input trp_pkg::trp_reg_t kind);
    logic [29:0] base;
    logic [29:0] idx;
    // Timers repeat the same four registers one stride apart
    base = trp_pkg::IDX_STRIDE * 30'(inst);
    if (kind == trp_pkg::TRP_REG_RELOAD_HIGH) begin
      idx = trp_pkg::IDX_RELOAD_HIGH + base;
    end else if (kind == trp_pkg::TRP_REG_RELOAD_LOW) begin
      idx = trp_pkg::IDX_RELOAD_LOW + base;
    end else if (kind == trp_pkg::TRP_REG_COMPARE_HIGH) begin
      idx = trp_pkg::IDX_COMPARE_HIGH + base;
    end else begin
      idx = trp_pkg::IDX_COMPARE_LOW + base;
    end
    return idx;
  endfunction : trp_index

  // Decode of the word index; a miss leaves hit low
  function automatic trp_pkg::trp_dec_t trp_decode(input logic [31:0] addr);
    trp_pkg::trp_dec_t r;
    trp_pkg::trp_reg_t kind;
    logic [29:0]       idx;
    r   = '{hit: 1'h0, inst: 2'h0, sel: trp_pkg::TRP_REG_RELOAD_HIGH};
    idx = addr[31:2];
    for (int unsigned i = 0; i < trp_pkg::NUM_TIMERS; i++) begin
      for (int s = 0; s < 4; s++) begin
        kind = trp_pkg::trp_reg_t'(s);
        if (idx == trp_index(i, kind)) begin
          r = '{hit: 1'h1, inst: 2'(i), sel: kind};
        end
      end
    end
    return r;
  endfunction : trp_decode

  // Software view of the compare/capture pair
  function automatic logic [15:0] trp_compare_value(input trp_pkg::trp_timer_state_t t);
    return {t.compare_high_field, t.compare_low_field};
  endfunction : trp_compare_value

  // Committed reload pair; the holding byte never shows here
  function automatic logic [15:0] trp_reload_value(input trp_pkg::trp_timer_state_t t);
    return {t.reload_high_field, t.reload_low_field};
  endfunction : trp_reload_value

  // Only a ticked count matches, so a stalled counter matches once
  function automatic logic trp_count_match(input trp_pkg::trp_timer_in_t ti,
                                           input logic [15:0]          value);
    return ti.count_tick && (ti.count == value);
  endfunction : trp_count_match

  // Byte that a read of one register returns
  function automatic logic [7:0] trp_read_byte(input trp_pkg::trp_timer_state_t t,
                                               input trp_pkg::trp_reg_t         kind);
    logic [7:0] b;
    if (kind == trp_pkg::TRP_REG_RELOAD_HIGH) begin
      b = t.reload_high_field;
    end else if (kind == trp_pkg::TRP_REG_RELOAD_LOW) begin
      b = t.reload_low_field;
    end else if (kind == trp_pkg::TRP_REG_COMPARE_HIGH) begin
      b = t.compare_high_field;
    end else begin
      b = t.compare_low_field;
    end
    return b;
  endfunction : trp_read_byte

  // APB side
  assign dec     = trp_decode(paddr);
  assign access  = psel & penable;
  // Registers answer in the access phase itself, no wait states
  assign pready  = 1'h1;
  // Unmapped index answers with an error and changes nothing
  assign pslverr = access & ~dec.hit;
  // Only byte lane 0 carries register data
  assign wr_en   = access & pwrite & dec.hit & pstrb[0];
  // Read data already stands in the setup phase
  assign rd_en   = psel & ~pwrite & dec.hit;
  assign rd_byte = trp_read_byte(state_q.tmr[dec.inst], dec.sel);

  // Write strobes, one register of one timer per access
  always_comb begin
    wr_hold_high  = 3'h0;
    wr_commit_low = 3'h0;
    wr_cmp_high   = 3'h0;
    wr_cmp_low    = 3'h0;
    for (int i = 0; i < int'(trp_pkg::NUM_TIMERS); i++) begin
      if (wr_en && dec.inst == 2'(i)) begin
        case (dec.sel)
          trp_pkg::TRP_REG_RELOAD_HIGH: begin
            wr_hold_high[i] = 1'h1;
          end
          trp_pkg::TRP_REG_RELOAD_LOW: begin
            wr_commit_low[i] = 1'h1;
          end
          trp_pkg::TRP_REG_COMPARE_HIGH: begin
            wr_cmp_high[i] = 1'h1;
          end
          default: begin
            wr_cmp_low[i] = 1'h1;
          end
        endcase
      end
    end
  end

  // Timer-side events
  always_comb begin
    capture_load = 3'h0;
    toggle       = 3'h0;
    for (int i = 0; i < int'(trp_pkg::NUM_TIMERS); i++) begin
      capture_load[i] = tmr_in[i].capture_mode && tmr_in[i].capture_event;
      // Registers hold captures in capture modes, so no compare then
      toggle[i]       = !tmr_in[i].capture_mode &&
                        trp_count_match(tmr_in[i],
                                        trp_compare_value(state_q.tmr[i]));
    end
  end

  // Next state of every timer
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < int'(trp_pkg::NUM_TIMERS); i++) begin
      if (wr_hold_high[i]) begin
        state_d.tmr[i].hold_high = pwdata[7:0];
      end
      // Both halves move on one edge, so the counter never sees a torn value
      if (wr_commit_low[i]) begin
        state_d.tmr[i].reload_high_field = state_q.tmr[i].hold_high;
        state_d.tmr[i].reload_low_field  = pwdata[7:0];
      end
      if (wr_cmp_high[i]) begin
        state_d.tmr[i].compare_high_field = pwdata[7:0];
      end
      if (wr_cmp_low[i]) begin
        state_d.tmr[i].compare_low_field = pwdata[7:0];
      end
      // Capture beats a same-cycle software write so no event is lost
      if (capture_load[i]) begin
        state_d.tmr[i].compare_high_field = tmr_in[i].count[15:8];
        state_d.tmr[i].compare_low_field  = tmr_in[i].count[7:0];
      end
      if (toggle[i]) begin
        state_d.tmr[i].pwm_state = ~state_q.tmr[i].pwm_state;
      end
      // Polarity applies after the toggle, so a flip shows one edge later
      state_d.tmr[i].pwm_out = state_d.tmr[i].pwm_state ^ tmr_in[i].output_polarity_bit;
    end
  end

  // Async reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < int'(trp_pkg::NUM_TIMERS); i++) begin
        state_q.tmr[i].hold_high          <= trp_pkg::RST_HOLD_HIGH;
        state_q.tmr[i].reload_high_field  <= trp_pkg::RST_RELOAD_HIGH;
        state_q.tmr[i].reload_low_field   <= trp_pkg::RST_RELOAD_LOW;
        state_q.tmr[i].compare_high_field <= trp_pkg::RST_COMPARE_HIGH;
        state_q.tmr[i].compare_low_field  <= trp_pkg::RST_COMPARE_LOW;
        state_q.tmr[i].pwm_state          <= 1'b0;
        state_q.tmr[i].pwm_out            <= 1'b0;
      end
    end else begin
      state_q <= state_d;
    end
  end

  // Read data, zero outside a mapped read
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      prdata[7:0] = rd_byte;
    end
  end

  // Timer outputs
  always_comb begin
    for (int i = 0; i < int'(trp_pkg::NUM_TIMERS); i++) begin
      tmr_out[i].reload_value  = trp_reload_value(state_q.tmr[i]);
      // Counter must load RELOAD_START when this is high on a tick
      tmr_out[i].reload_hit    = trp_count_match(tmr_in[i],
                                                 trp_reload_value(state_q.tmr[i]));
      tmr_out[i].compare_match = toggle[i];
      tmr_out[i].pwm_out       = state_q.tmr[i].pwm_out;
    end
  end

endmodule : trp_timer_reload_pwm_regs

// ==== trp_timer_reload_pwm_regs_monitor.sv ====
// Concurrent checks on the timer register block, timer 0 outputs only.
// Assumes zero-wait APB and the port set of the register block.
module trp_regs_monitor (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic [31:0]            prdata,
  input wire trp_pkg::trp_timer_in_t  [2:0] tmr_in,
  input wire trp_pkg::trp_timer_out_t [2:0] tmr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire        wr = psel && penable && pwrite && pstrb[0];
  wire        rd = psel && penable && !pwrite;
  wire [29:0] ix = paddr[31:2];
  hold_only_a: assert property (wr && ix == trp_pkg::IDX_RELOAD_HIGH
    |=> $stable(tmr_out[0].reload_value)) else $error("reload moved on high write");
  low_commit_a: assert property (wr && ix == trp_pkg::IDX_RELOAD_LOW
    |=> tmr_out[0].reload_value[7:0] == $past(pwdata[7:0])) else $error("low not committed");
  reload_hit_a: assert property (tmr_out[0].reload_hit == (tmr_in[0].count_tick
    && tmr_in[0].count == tmr_out[0].reload_value)) else $error("reload hit wrong");
  pwm_toggle_a: assert property (tmr_out[0].compare_match
    && $stable(tmr_in[0].output_polarity_bit) |=> tmr_out[0].pwm_out != $past(tmr_out[0].pwm_out))
    else $error("no toggle on match");
  pol_flip_a: assert property (!tmr_out[0].compare_match
    && $changed(tmr_in[0].output_polarity_bit) |=> $changed(tmr_out[0].pwm_out))
    else $error("polarity not applied");
  capture_load_a: assert property (tmr_in[0].capture_mode && tmr_in[0].capture_event
    ##1 rd && ix == trp_pkg::IDX_COMPARE_LOW |-> prdata == {24'h0, $past(tmr_in[0].count[7:0])})
    else $error("capture not loaded");
  timer_stride_a: assert property (wr && ix == trp_pkg::IDX_RELOAD_LOW + trp_pkg::IDX_STRIDE
    |=> $stable(tmr_out[0].reload_value)) else $error("timer 1 write hit timer 0");
  read_commit_a: assert property (rd && ix == trp_pkg::IDX_RELOAD_HIGH
    |-> prdata == {24'h0, tmr_out[0].reload_value[15:8]}) else $error("reload read wrong");
endmodule : trp_regs_monitor

// ==== trp_timer_reload_pwm_regs_test.sv ====
// Self-checking bench for the timer reload and compare/capture registers.
// Assumes the zero-wait APB slave and per-timer counter inputs of the design.
module trp_timer_reload_pwm_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          pclk = 1'h0, presetn = 1'h0;
  logic                          psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0]                   paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic [3:0]                    pstrb = 4'h1;
  logic                          pready, pslverr, e;
  trp_pkg::trp_timer_in_t  [2:0] tmr_in = '0;
  trp_pkg::trp_timer_out_t [2:0] tmr_out;
  int                            bad_count = 0, checks_done = 0;
  // Write offset, data, read offset, expected byte
  logic [23:0]                   rows [4] = '{24'h0_12_0_ff, 24'h1_34_0_12,
                                              24'h2_56_2_56, 24'h3_78_3_78};
  always #10 pclk = ~pclk;
  trp_timer_reload_pwm_regs u_trp_timer_reload_pwm_regs (.*);
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, x);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // One idle edge first, so back-to-back calls never reassign psel in one step
  task automatic xfer(input logic w, input logic [29:0] ix, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= {ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      bad_count++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    xfer(1'h0, trp_pkg::IDX_RELOAD_LOW, 8'h0);
    chk(r, 32'hff);
    chk(tmr_out[2].reload_value, 16'hffff);
    for (int t = 0; t < 3; t++) begin
      for (int i = 0; i < 4; i++) begin
        xfer(1'h1, trp_pkg::IDX_RELOAD_HIGH + rows[i][23:20] + 30'(t) * trp_pkg::IDX_STRIDE,
             rows[i][19:12]);
        xfer(1'h0, trp_pkg::IDX_RELOAD_HIGH + rows[i][11:8] + 30'(t) * trp_pkg::IDX_STRIDE, 8'h0);
        chk(r, {24'h0, rows[i][7:0]});
      end
    end
    chk({tmr_out[0].reload_value, tmr_out[2].reload_value}, 32'h1234_1234);
    @(posedge pclk);
    tmr_in[0].count      <= 16'h1234;
    tmr_in[0].count_tick <= 1'h1;
    @(negedge pclk);
    chk(tmr_out[0].reload_hit, 1'h1);
    @(posedge pclk);
    tmr_in[0].count <= 16'h5678;
    @(negedge pclk);
    chk({tmr_out[0].reload_hit, tmr_out[0].compare_match}, 2'h1);
    @(posedge pclk);
    tmr_in[0].count_tick <= 1'h0;
    @(negedge pclk);
    chk(tmr_out[0].pwm_out, 1'h1);
    @(posedge pclk);
    tmr_in[0].output_polarity_bit <= 1'h1;
    repeat (2) @(negedge pclk);
    chk(tmr_out[0].pwm_out, 1'h0);
    @(posedge pclk);
    tmr_in[0] <= '{16'habcd, 1'h0, 1'h1, 1'h1, 1'h1};
    xfer(1'h0, trp_pkg::IDX_COMPARE_LOW, 8'h0);
    chk(r, 32'hcd);
    xfer(1'h0, 30'h0, 8'h0);
    chk({e, r[30:0]}, 32'h8000_0000);
    // Capture keeps beating a software write
    xfer(1'h1, trp_pkg::IDX_COMPARE_LOW, 8'h11);
    xfer(1'h0, trp_pkg::IDX_COMPARE_LOW, 8'h0);
    chk(r, 32'hcd);
    // Ticked match in capture mode must not toggle
    @(posedge pclk);
    tmr_in[0] <= '{16'habcd, 1'h1, 1'h1, 1'h0, 1'h1};
    @(negedge pclk);
    chk(tmr_out[0].compare_match, 1'h0);
    @(negedge pclk);
    chk(tmr_out[0].pwm_out, 1'h0);
    // Write without lane 0 is ignored
    @(posedge pclk);
    tmr_in[0] <= '0;
    pstrb     <= 4'h0;
    xfer(1'h1, trp_pkg::IDX_COMPARE_HIGH + trp_pkg::IDX_STRIDE, 8'h99);
    pstrb <= 4'h1;
    xfer(1'h0, trp_pkg::IDX_COMPARE_HIGH + trp_pkg::IDX_STRIDE, 8'h0);
    chk(r, 32'h56);
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    chk(tmr_out[1].reload_value, 16'hffff);
    chk(tmr_out[0].pwm_out, 1'h0);
    xfer(1'h0, trp_pkg::IDX_COMPARE_LOW + 30'(2) * trp_pkg::IDX_STRIDE, 8'h0);
    chk(r, 32'h0);
    xfer(1'h1, trp_pkg::IDX_RELOAD_LOW + 30'(2) * trp_pkg::IDX_STRIDE, 8'h42);
    @(negedge pclk);
    chk(tmr_out[2].reload_value, 16'hff42);
    tally_and_finish();
  end
endmodule : trp_timer_reload_pwm_regs_test
bind trp_timer_reload_pwm_regs trp_regs_monitor u_trp_regs_monitor (.*);
